// [exc_unit_pkg.sv]
// shared constants and carriers for the fp and watch exception unit
package exc_unit_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PA_W   = 40;
  localparam int PC_W   = 64;

  // register offsets of the block's own map
  localparam logic [ADDR_W-1:0] OFF_MATCH_LO = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MATCH_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FCSR     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CAUSE    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EPC_LO   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EPC_HI   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;

  // match address low: [31:3] pa[31:3], [1] load enable, [0] store enable
  localparam int LO_LOAD_BIT  = 1;
  localparam int LO_STORE_BIT = 0;
  localparam int LO_ADDR_LSB  = 3;
  localparam int HI_ADDR_W    = PA_W - DATA_W;

  // fcsr: cause field [17:12], enable/flag bits kept as plain storage
  localparam int FCSR_CAUSE_LSB = 12;
  localparam int FCSR_CAUSE_W   = 6;

  // status: [2] error level, [1] exception level
  localparam int ST_ERL_BIT = 2;
  localparam int ST_EXL_BIT = 1;

  // cause register: code field [6:2]
  localparam int CAUSE_CODE_LSB = 2;
  localparam int CODE_W         = 5;
  localparam logic [CODE_W-1:0] FLOAT_FAULT_CODE = 5'h0f;
  localparam logic [CODE_W-1:0] WATCH_CODE       = 5'h17;

  // irq event bits
  localparam int IRQ_FP_BIT    = 0;
  localparam int IRQ_WATCH_BIT = 1;
  localparam int IRQ_W         = 2;

  localparam logic [PC_W-1:0] GENERAL_VECTOR = 64'hffff_ffff_8000_0180;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  typedef struct packed {
    logic            valid;
    logic            isLoad;
    logic            isStore;
    logic            isCacheOp;
    logic            cacheable;
    logic            dcacheHit;
    logic [PA_W-1:0] pa;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] nextPc;
  } mem_access_s;

  typedef struct packed {
    logic            redirect;
    logic [PC_W-1:0] target;
    logic            killAccess;
    logic            refillOnly;
  } redirect_s;

endpackage

// [fp_and_watch_exception_logic.sv]
// floating-point and watch exception unit with register port
//
// Overview of operation
// - fp exception only on fpu request, unmaskable
// - both exceptions vector generally and record cause
// - fcsr holds readable fp exception cause
// - clearing all fcsr cause bits ends fp request
// - watch fires on access matching watch address
// - low register selects load and store qualify
// - cacheable missed watch access still refills
// - otherwise watch access leaves caches untouched
// - cache maintenance ops never trigger watch
// - exl or erl defers watch until clear
// - deferred watch epc is next unexecuted instruction
// - reset or low register write discards pending
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module fp_and_watch_exception_logic
(
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  input  wire exc_unit_pkg::reg_req_s         regReq,
  output logic [exc_unit_pkg::DATA_W-1:0]     regRdata,
  input  wire logic                           fpuRaise,
  input  wire logic [exc_unit_pkg::FCSR_CAUSE_W-1:0] fpuCause,
  input  wire exc_unit_pkg::mem_access_s      memAccess,
  input  wire logic                           pipeIdle,
  input  wire logic [exc_unit_pkg::PC_W-1:0]  pipeNextPc,
  output exc_unit_pkg::redirect_s             redirect,
  output logic                                watchPending,
  output logic                                fpRequest,
  output logic                                irq
);

  typedef struct packed {
    logic [exc_unit_pkg::DATA_W-1:0]    matchLo;
    logic [exc_unit_pkg::HI_ADDR_W-1:0] matchHi;
    logic [exc_unit_pkg::DATA_W-1:0]    fcsr;
    logic                               exlBit;
    logic                               erlBit;
    logic [exc_unit_pkg::CODE_W-1:0]    code;
    logic [exc_unit_pkg::PC_W-1:0]      exception_return_pc;
    logic                               pend;
    logic [exc_unit_pkg::IRQ_W-1:0]     irqStat;
    logic [exc_unit_pkg::IRQ_W-1:0]     irqMask;
    exc_unit_pkg::redirect_s            redir;
    logic [exc_unit_pkg::DATA_W-1:0]    rdata;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic   rstSync1_q;
  logic   rstSync2_q;

  // release is synchronised; assertion stays asynchronous
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  function automatic logic regHit(input exc_unit_pkg::reg_req_s r,
                                  input logic [exc_unit_pkg::ADDR_W-1:0] off);
    regHit = r.addr == off;
  endfunction

  function automatic logic watchMatch(
    input exc_unit_pkg::mem_access_s a,
    input logic [exc_unit_pkg::DATA_W-1:0] lo,
    input logic [exc_unit_pkg::HI_ADDR_W-1:0] hi);
    logic qual;
    qual = (a.isLoad && lo[exc_unit_pkg::LO_LOAD_BIT])
        || (a.isStore && lo[exc_unit_pkg::LO_STORE_BIT]);
    watchMatch = a.valid && qual && !a.isCacheOp
      && a.pa[exc_unit_pkg::PA_W-1:exc_unit_pkg::DATA_W] == hi
      && a.pa[exc_unit_pkg::DATA_W-1:exc_unit_pkg::LO_ADDR_LSB]
         == lo[exc_unit_pkg::DATA_W-1:exc_unit_pkg::LO_ADDR_LSB];
  endfunction

  logic fpCauseLive;
  logic matchNow;
  logic blocked;

  always_comb
  begin
    s_d = s_q;
    s_d.redir = '0;
    s_d.rdata = '0;
    fpCauseLive = |s_q.fcsr[exc_unit_pkg::FCSR_CAUSE_LSB +:
                            exc_unit_pkg::FCSR_CAUSE_W];
    matchNow = watchMatch(memAccess, s_q.matchLo, s_q.matchHi);
    blocked = s_q.exlBit || s_q.erlBit;

    // fpu reports its cause into the fcsr; set wins over software clear
    if (regReq.wr && regHit(regReq, exc_unit_pkg::OFF_FCSR))
      s_d.fcsr = regReq.wdata;
    if (fpuRaise)
      s_d.fcsr[exc_unit_pkg::FCSR_CAUSE_LSB +: exc_unit_pkg::FCSR_CAUSE_W]
        = s_d.fcsr[exc_unit_pkg::FCSR_CAUSE_LSB +:
                   exc_unit_pkg::FCSR_CAUSE_W] | fpuCause;

    if (regReq.wr && regHit(regReq, exc_unit_pkg::OFF_MATCH_HI))
      s_d.matchHi = regReq.wdata[exc_unit_pkg::HI_ADDR_W-1:0];
    if (regReq.wr && regHit(regReq, exc_unit_pkg::OFF_STATUS))
    begin
      s_d.exlBit = regReq.wdata[exc_unit_pkg::ST_EXL_BIT];
      s_d.erlBit = regReq.wdata[exc_unit_pkg::ST_ERL_BIT];
    end
    if (regReq.wr && regHit(regReq, exc_unit_pkg::OFF_IRQ_MASK))
      s_d.irqMask = regReq.wdata[exc_unit_pkg::IRQ_W-1:0];
    if (regReq.wr && regHit(regReq, exc_unit_pkg::OFF_IRQ_STAT))
      s_d.irqStat = s_q.irqStat & ~regReq.wdata[exc_unit_pkg::IRQ_W-1:0];

    // a watch match under exl/erl lets the access finish and waits
    if (matchNow && blocked)
      s_d.pend = 1'b1;

    if (matchNow && !blocked)
    begin
      s_d.redir.redirect = 1'b1;
      s_d.redir.target = exc_unit_pkg::GENERAL_VECTOR;
      // a missed cacheable line still refills; nothing else touches cache
      s_d.redir.refillOnly = memAccess.cacheable
                           && !memAccess.dcacheHit;
      s_d.redir.killAccess = !s_d.redir.refillOnly;
      s_d.code = exc_unit_pkg::WATCH_CODE;
      s_d.exception_return_pc = memAccess.pc;
      s_d.exlBit = 1'b1;
      s_d.irqStat[exc_unit_pkg::IRQ_WATCH_BIT] = 1'b1;
    end
    else if (s_q.pend && !blocked && pipeIdle)
    begin
      // epc points past the access that already completed
      s_d.redir.redirect = 1'b1;
      s_d.redir.target = exc_unit_pkg::GENERAL_VECTOR;
      s_d.code = exc_unit_pkg::WATCH_CODE;
      s_d.exception_return_pc = pipeNextPc;
      s_d.exlBit = 1'b1;
      s_d.pend = 1'b0;
      s_d.irqStat[exc_unit_pkg::IRQ_WATCH_BIT] = 1'b1;
    end
    else if (fpCauseLive && !s_q.exlBit && !s_q.erlBit && pipeIdle)
    begin
      // no mask bit is consulted here: only exl/erl serialise entry
      s_d.redir.redirect = 1'b1;
      s_d.redir.target = exc_unit_pkg::GENERAL_VECTOR;
      s_d.code = exc_unit_pkg::FLOAT_FAULT_CODE;
      s_d.exception_return_pc = pipeNextPc;
      s_d.exlBit = 1'b1;
      s_d.irqStat[exc_unit_pkg::IRQ_FP_BIT] = 1'b1;
    end

    // writing the low match register drops any deferred watch
    if (regReq.wr && regHit(regReq, exc_unit_pkg::OFF_MATCH_LO))
    begin
      s_d.matchLo = regReq.wdata;
      s_d.pend = 1'b0;
    end

    if (regReq.rd)
    begin
      unique case (regReq.addr)
        exc_unit_pkg::OFF_MATCH_LO: s_d.rdata = s_q.matchLo;
        exc_unit_pkg::OFF_MATCH_HI:
          s_d.rdata = {{(exc_unit_pkg::DATA_W-exc_unit_pkg::HI_ADDR_W){1'b0}},
                       s_q.matchHi};
        exc_unit_pkg::OFF_FCSR:     s_d.rdata = s_q.fcsr;
        exc_unit_pkg::OFF_STATUS:
        begin
          s_d.rdata[exc_unit_pkg::ST_EXL_BIT] = s_q.exlBit;
          s_d.rdata[exc_unit_pkg::ST_ERL_BIT] = s_q.erlBit;
        end
        exc_unit_pkg::OFF_CAUSE:
          s_d.rdata[exc_unit_pkg::CAUSE_CODE_LSB +: exc_unit_pkg::CODE_W]
            = s_q.code;
        exc_unit_pkg::OFF_EPC_LO:
          s_d.rdata = s_q.exception_return_pc[exc_unit_pkg::DATA_W-1:0];
        exc_unit_pkg::OFF_EPC_HI:
          s_d.rdata = s_q.exception_return_pc[exc_unit_pkg::PC_W-1:exc_unit_pkg::DATA_W];
        exc_unit_pkg::OFF_IRQ_STAT:
          s_d.rdata[exc_unit_pkg::IRQ_W-1:0] = s_q.irqStat;
        exc_unit_pkg::OFF_IRQ_MASK:
          s_d.rdata[exc_unit_pkg::IRQ_W-1:0] = s_q.irqMask;
        default:                    s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign regRdata     = s_q.rdata;
  assign redirect     = s_q.redir;
  assign watchPending = s_q.pend;
  // request drops as soon as the fcsr cause field reads zero
  assign fpRequest    = |s_q.fcsr[exc_unit_pkg::FCSR_CAUSE_LSB +:
                                  exc_unit_pkg::FCSR_CAUSE_W];
  assign irq          = |(s_q.irqStat & s_q.irqMask);

  property p_fp_unmaskable;
    @(posedge mclk) disable iff (!rstSync2_q)
    fpRequest && !s_q.exlBit && !s_q.erlBit && pipeIdle
      && !matchNow && !s_q.pend
    |=> redirect.redirect
        && s_q.code == exc_unit_pkg::FLOAT_FAULT_CODE;
  endproperty
  a_fp_unmaskable: assert property (p_fp_unmaskable)
    else $error("fp request not taken");

  property p_vector;
    @(posedge mclk) disable iff (!rstSync2_q)
    redirect.redirect |-> redirect.target == exc_unit_pkg::GENERAL_VECTOR
      && s_q.exlBit;
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong exception vector");

  property p_fcsr_capture;
    @(posedge mclk) disable iff (!rstSync2_q)
    fpuRaise && fpuCause != '0 |=> fpRequest;
  endproperty
  a_fcsr_capture: assert property (p_fcsr_capture)
    else $error("fp cause not recorded");

  property p_fp_clear;
    @(posedge mclk) disable iff (!rstSync2_q)
    !fpRequest && !fpuRaise
      && !(regReq.wr && regReq.addr == exc_unit_pkg::OFF_FCSR)
    |=> !fpRequest;
  endproperty
  a_fp_clear: assert property (p_fp_clear)
    else $error("fp request without cause");

  property p_watch_take;
    @(posedge mclk) disable iff (!rstSync2_q)
    matchNow && !blocked |=> redirect.redirect
      && s_q.code == exc_unit_pkg::WATCH_CODE
      && s_q.exception_return_pc == $past(memAccess.pc);
  endproperty
  a_watch_take: assert property (p_watch_take)
    else $error("watch match not taken");

  property p_no_qual;
    @(posedge mclk) disable iff (!rstSync2_q)
    !s_q.matchLo[exc_unit_pkg::LO_LOAD_BIT]
      && !s_q.matchLo[exc_unit_pkg::LO_STORE_BIT] |-> !matchNow;
  endproperty
  a_no_qual: assert property (p_no_qual)
    else $error("match with qualifiers clear");

  property p_cacheop;
    @(posedge mclk) disable iff (!rstSync2_q)
    memAccess.isCacheOp |-> !matchNow;
  endproperty
  a_cacheop: assert property (p_cacheop)
    else $error("cache op matched watch");

  property p_refill;
    @(posedge mclk) disable iff (!rstSync2_q)
    matchNow && !blocked && memAccess.cacheable && !memAccess.dcacheHit
    |=> redirect.refillOnly && !redirect.killAccess;
  endproperty
  a_refill: assert property (p_refill)
    else $error("missed refill on watch");

  property p_defer;
    @(posedge mclk) disable iff (!rstSync2_q)
    matchNow && blocked && !(regReq.wr
      && regReq.addr == exc_unit_pkg::OFF_MATCH_LO)
    |=> watchPending && !redirect.redirect;
  endproperty
  a_defer: assert property (p_defer)
    else $error("watch not deferred");

  property p_discard;
    @(posedge mclk) disable iff (!rstSync2_q)
    regReq.wr && regReq.addr == exc_unit_pkg::OFF_MATCH_LO |=> !watchPending;
  endproperty
  a_discard: assert property (p_discard)
    else $error("pending watch survived write");

  property p_fp_sw_clear;
    @(posedge mclk) disable iff (!rstSync2_q)
    regReq.wr && regReq.addr == exc_unit_pkg::OFF_FCSR && !fpuRaise
      && regReq.wdata[exc_unit_pkg::FCSR_CAUSE_LSB +:
                      exc_unit_pkg::FCSR_CAUSE_W] == '0
    |=> !fpRequest;
  endproperty
  a_fp_sw_clear: assert property (p_fp_sw_clear)
    else $error("fp request outlived software clear");

  // no refill means the access must be squashed outright
  property p_keep_cache;
    @(posedge mclk) disable iff (!rstSync2_q)
    matchNow && !blocked
      && !(memAccess.cacheable && !memAccess.dcacheHit)
    |=> redirect.killAccess && !redirect.refillOnly;
  endproperty
  a_keep_cache: assert property (p_keep_cache)
    else $error("watch access touched cache");

  property p_qualify;
    @(posedge mclk) disable iff (!rstSync2_q)
    memAccess.isStore && !memAccess.isLoad
      && !s_q.matchLo[exc_unit_pkg::LO_STORE_BIT] |-> !matchNow;
  endproperty
  a_qualify: assert property (p_qualify)
    else $error("store matched with store qualifier clear");

  property p_deferred_epc;
    @(posedge mclk) disable iff (!rstSync2_q)
    s_q.pend && !blocked && pipeIdle && !matchNow
    |=> redirect.redirect && !watchPending
      && s_q.exception_return_pc == $past(pipeNextPc);
  endproperty
  a_deferred_epc: assert property (p_deferred_epc)
    else $error("deferred watch epc wrong");

  property p_pend_hold;
    @(posedge mclk) disable iff (!rstSync2_q)
    watchPending && blocked
      && !(regReq.wr && regReq.addr == exc_unit_pkg::OFF_MATCH_LO)
    |=> watchPending;
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("deferred watch lost while blocked");

  c_fp: cover property (@(posedge mclk) disable iff (!rstSync2_q)
    redirect.redirect && s_q.code == exc_unit_pkg::FLOAT_FAULT_CODE);
  c_deferred: cover property (@(posedge mclk) disable iff (!rstSync2_q)
    watchPending ##[1:20] !watchPending && redirect.redirect);
  c_refill: cover property (@(posedge mclk) disable iff (!rstSync2_q)
    redirect.refillOnly);
  c_watch_now: cover property (@(posedge mclk) disable iff (!rstSync2_q)
    matchNow && !blocked);

endmodule

`default_nettype wire

// [pipe_partner.sv]
// pipeline and fpu side model feeding the exception unit
`timescale 1ns/1ps
`default_nettype none
module pipe_partner
(
  input  wire logic                                  mclk,
  input  wire logic                                  goAcc,
  input  wire exc_unit_pkg::mem_access_s             accIn,
  input  wire logic                                  goFp,
  input  wire logic [exc_unit_pkg::FCSR_CAUSE_W-1:0] fpCauseIn,
  output exc_unit_pkg::mem_access_s                  memAccess,
  output logic                                       fpuRaise,
  output logic [exc_unit_pkg::FCSR_CAUSE_W-1:0]      fpuCause
);
  initial
  begin
    memAccess = '0;
    fpuRaise  = 1'b0;
    fpuCause  = '0;
  end
  // a dead slot clears valid, which keeps it from matching; the stale address flips back and forth, inverted on every idle cycle
  always @(posedge mclk)
  begin
    if (goAcc)
      memAccess <= accIn;
    else
    begin
      memAccess.valid <= 1'b0;
      memAccess.pa    <= ~memAccess.pa;
    end
    fpuRaise <= goFp;
    fpuCause <= goFp ? fpCauseIn : ~fpuCause;
  end
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the fp and watch exception unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                      mclk, reset_n, goAcc, goFp, pipeIdle, fpuRaise;
  logic                      irq, watchPending, fpRequest;
  logic [5:0]                fpCauseIn, fpuCause;
  logic [31:0]               regRdata, rv;
  logic [63:0]               pipeNextPc, pc;
  logic [39:0]               wpa;
  exc_unit_pkg::reg_req_s    regReq;
  exc_unit_pkg::mem_access_s accIn, memAccess;
  exc_unit_pkg::redirect_s   redirect;
  int                        num_errors, n_tests, expStat, mask, k;

  fp_and_watch_exception_logic dut (.mclk(mclk), .reset_n(reset_n),
    .regReq(regReq), .regRdata(regRdata), .fpuRaise(fpuRaise),
    .fpuCause(fpuCause), .memAccess(memAccess), .pipeIdle(pipeIdle),
    .pipeNextPc(pipeNextPc), .redirect(redirect),
    .watchPending(watchPending), .fpRequest(fpRequest), .irq(irq));
  pipe_partner partner (.mclk(mclk), .goAcc(goAcc), .accIn(accIn),
    .goFp(goFp), .fpCauseIn(fpCauseIn), .memAccess(memAccess),
    .fpuRaise(fpuRaise), .fpuCause(fpuCause));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    regReq.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    regReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    regReq.rd <= 1'b0;
    #1 v = regRdata;
  endtask

  task automatic access(input logic ld, st, cop, cab, hit);
    @(posedge mclk);
    pc = {$urandom, $urandom};
    accIn <= '{1'b1, ld, st, cop, cab, hit, wpa, pc, pc + 64'h4};
    goAcc <= 1'b1;
    @(posedge mclk);
    goAcc <= 1'b0;
  endtask

  task automatic noTrap();
    repeat (6)
    begin
      @(posedge mclk);
      #1 check("redirect idle", redirect.redirect, 1'b0);
    end
  endtask

  // refill below zero skips the cache action checks
  task automatic trap(input logic [4:0] code, input logic [63:0] exception_return_pc,
                      input int refill);
    for (k = 0; k < 12 && redirect.redirect !== 1'b1; k++)
      @(posedge mclk) #1;
    check("redirect", redirect.redirect, 1'b1);
    check("target", redirect.target, exc_unit_pkg::GENERAL_VECTOR);
    if (refill >= 0)
    begin
      check("refillOnly", redirect.refillOnly, refill[0]);
      check("killAccess", redirect.killAccess, !refill[0]);
    end
    expStat |= (code == exc_unit_pkg::WATCH_CODE) ? 2 : 1;
    rd(exc_unit_pkg::OFF_CAUSE, rv);
    check("cause code", rv[6:2], code);
    rd(exc_unit_pkg::OFF_EPC_LO, rv);
    check("epc low", rv, exception_return_pc[31:0]);
    rd(exc_unit_pkg::OFF_EPC_HI, rv);
    check("epc high", rv, exception_return_pc[63:32]);
    check("irq", irq, (expStat & mask) != 0);
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(33413));
    {reset_n, goAcc, goFp, pipeIdle, fpCauseIn} = '0;
    {regReq, accIn, pipeNextPc} = '0;
    {num_errors, n_tests, expStat, mask} = '0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 check("pending at reset", {watchPending, fpRequest, irq}, 3'b000);
    wr(exc_unit_pkg::OFF_IRQ_MASK, 32'h3);
    mask = 3;
    wpa = 40'({$urandom, $urandom});
    wr(exc_unit_pkg::OFF_MATCH_HI, {24'h0, wpa[39:32]});
    wr(exc_unit_pkg::OFF_MATCH_LO, {wpa[31:3], 3'b010});
    access(0, 1, 0, 0, 0); noTrap();
    access(1, 0, 1, 1, 0); noTrap();
    for (int i = 0; i < 4; i++)
    begin
      wr(exc_unit_pkg::OFF_MATCH_LO, {wpa[31:3], i[0], 2'b11});
      access(i[0], !i[0], 0, i[1], i[0]);
      trap(exc_unit_pkg::WATCH_CODE, pc, i == 2);
      wr(exc_unit_pkg::OFF_STATUS, 32'h0);
    end
    wr(exc_unit_pkg::OFF_MATCH_LO, {wpa[31:3], 3'b000});
    access(1, 0, 0, 1, 1); noTrap();
    wr(exc_unit_pkg::OFF_MATCH_LO, {wpa[31:3], 3'b001});
    wr(exc_unit_pkg::OFF_STATUS, 32'h4);
    pipeNextPc <= {$urandom, $urandom};
    access(0, 1, 0, 0, 0); noTrap();
    check("deferred", watchPending, 1'b1);
    wr(exc_unit_pkg::OFF_STATUS, 32'h0);
    noTrap();
    @(posedge mclk);
    pipeIdle <= 1'b1;
    trap(exc_unit_pkg::WATCH_CODE, pipeNextPc, -1);
    check("deferred taken", watchPending, 1'b0);
    wr(exc_unit_pkg::OFF_STATUS, 32'h2);
    access(0, 1, 0, 0, 0); noTrap();
    wr(exc_unit_pkg::OFF_MATCH_LO, {wpa[31:3], 3'b001});
    @(posedge mclk) #1 check("discard", watchPending, 1'b0);
    wr(exc_unit_pkg::OFF_STATUS, 32'h0); noTrap();
    wr(exc_unit_pkg::OFF_IRQ_MASK, 32'h0);
    mask = 0;
    wr(exc_unit_pkg::OFF_STATUS, 32'h2);
    @(posedge mclk);
    fpCauseIn <= 6'($urandom % 63 + 1);
    goFp <= 1'b1;
    @(posedge mclk);
    goFp <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 check("fp request", fpRequest, 1'b1);
    rd(exc_unit_pkg::OFF_FCSR, rv);
    check("fcsr cause", rv[17:12], fpCauseIn);
    wr(exc_unit_pkg::OFF_STATUS, 32'h0);
    trap(exc_unit_pkg::FLOAT_FAULT_CODE, pipeNextPc, -1);
    wr(exc_unit_pkg::OFF_FCSR, 32'h0);
    @(posedge mclk) #1 check("fp cleared", fpRequest, 1'b0);
    wr(exc_unit_pkg::OFF_STATUS, 32'h0); noTrap();
    rd(exc_unit_pkg::OFF_IRQ_STAT, rv);
    check("irq status", rv, expStat);
    wr(exc_unit_pkg::OFF_IRQ_MASK, 32'h3);
    @(posedge mclk) #1 check("irq", irq, 1'b1);
    for (int b = 1; b <= 2; b++)
    begin
      wr(exc_unit_pkg::OFF_IRQ_STAT, b);
      expStat &= ~b;
      @(posedge mclk) #1 check("irq clear", irq, expStat != 0);
    end
    rd(8'h24, rv);
    check("unmapped", rv, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
